// [ras_node_pkg.sv]
// shared constants for the error reporting node
package ras_node_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  // register offsets
  localparam logic [11:0] OFF_FEATURE = 12'h000;
  localparam logic [11:0] OFF_CONTROL = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_FAULT_ADDR = 12'h018;
  localparam logic [11:0] OFF_COUNTER = 12'h020;
  localparam logic [11:0] OFF_SCRUB = 12'h028;
  localparam logic [11:0] OFF_ROUTE = 12'h030;
  localparam logic [11:0] OFF_GROUP_STATUS = 12'hE00;
  // feature register fields
  localparam int FR_FI = 2;
  localparam int FR_UI = 4;
  localparam int FR_DUI = 6;
  localparam int FR_CEC = 12;
  localparam int FR_CFI = 10;
  localparam logic [1:0] FR_CTRL_PRESENT = 2'h2;
  localparam logic [2:0] FR_CEC_16 = 3'h4;
  // control register bits
  localparam int CTL_EN = 0;
  localparam int CTL_UI = 2;
  localparam int CTL_FI = 3;
  localparam int CTL_CFI = 8;
  localparam int CTL_DUI = 9;
  localparam int CTL_SWF_RESP = 12;
  localparam int CTL_SWF_IRQ = 13;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_330D;
  // status register bits
  localparam int ST_V = 30;
  localparam int ST_UE = 29;
  localparam int ST_CE = 24;
  localparam int ST_DE = 23;
  localparam int ST_CI = 22;
  localparam int ST_ADDRV = 31;
  localparam logic [7:0] ETC_NONE = 8'h00;
  localparam logic [7:0] ETC_DATA = 8'h02;
  localparam logic [7:0] ETC_ILL_ADDR = 8'h0D;
  localparam logic [7:0] ETC_ILL_ACCESS = 8'h0E;
  localparam logic [7:0] ETC_ILL_STATE = 8'h0F;
  // fault address register: bit 31 of the 32-bit register is the type flag
  localparam int ADDR_TYPE_BIT = 31;
  // counter: top bit is the overflow bit
  localparam int CNT_OV = 15;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  // routing register bits
  localparam int ROUTE_CI_IC = 0;
  localparam int ROUTE_FH_SCP = 1;
  localparam int ROUTE_ER_SCP = 2;
  localparam logic [2:0] ROUTE_RESET = 3'h0;
  // patrol scrub register: bit 31 enable, low 16 bits interval
  localparam int SCRUB_EN = 31;
  localparam logic [15:0] SCRUB_INTERVAL_RESET = 16'h0100;
endpackage : ras_node_pkg

// [ras_error_node.sv]
// error reporting node with corrected error counter and apb registers
// Operation
// - one standard corrected error counter provided
// - counter is sixteen bits with overflow bit
// - single counter arrangement chosen
// - feature fields report control capability 0b10
// - one shared fault handling interrupt
// - one combined error recovery interrupt
// - one combined critical error interrupt
// - fault and recovery go to interrupt controller
// - critical to controller optional when to processor
// - interrupts are shared level lines
// - address type flag zero when system address
// - group status mirrors record status
// - reserved accesses read zero, writes ignored
// - other faulting accesses read zero, write ignored
// - unimplemented registers read zero
// - no location is treated as not present
// - no page is treated as absent
// - fault response and interrupt reset disabled
// - clean cache error invalidates the data
// - dirty cache errors classed by correction
// - background patrol scrub requests provided
// - software faults coded 13, 14, 15
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module ras_error_node
(
  input wire logic pclk, // bus clock 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ras_node_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [ras_node_pkg::DATA_W-1:0] pwdata, // apb write data
  output logic [ras_node_pkg::DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error response
  input wire logic ce_event, // corrected error pulse
  input wire logic de_event, // deferred error pulse
  input wire logic ue_event, // uncorrected error pulse
  input wire logic ci_event, // critical error pulse
  input wire logic [31:0] err_addr, // address of the error
  input wire logic err_addr_spa, // address equals system address
  input wire logic clean_det, // error in clean-only cache line
  output logic invalidate_req, // invalidate the affected line
  output logic scrub_req, // patrol scrub step request
  output logic fh_irq_ic, // fault handling to controller
  output logic fh_irq_scp, // fault handling to control cpu
  output logic er_irq_ic, // error recovery to controller
  output logic er_irq_scp, // error recovery to control cpu
  output logic ci_irq_scp, // critical to control cpu
  output logic ci_irq_ic // critical to controller
);
  import ras_node_pkg::*;

  // ***********************************
  // register state
  // ***********************************
  logic [31:0] control;
  logic [31:0] status;
  logic [31:0] fault_addr;
  logic [15:0] counter;
  logic [2:0] route;
  logic scrub_en;
  logic [15:0] scrub_interval;
  logic [15:0] scrub_cnt;
  logic setup;
  logic wr_acc;
  logic [31:0] feature;
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr_ro;
  logic wr_state;
  logic swf;
  logic [7:0] swf_code;
  logic swf_err;
  logic err_any;
  logic [15:0] next_counter;
  logic [31:0] next_status;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;

  // ***********************************
  // feature register
  // ***********************************
  always_comb begin
    feature = 32'h0000_0000;
    feature[FR_FI +: 2] = FR_CTRL_PRESENT;
    feature[FR_UI +: 2] = FR_CTRL_PRESENT;
    feature[FR_DUI +: 2] = FR_CTRL_PRESENT;
    feature[FR_CFI +: 2] = FR_CTRL_PRESENT;
    feature[FR_CEC +: 3] = FR_CEC_16;
  end

  // ***********************************
  // address decode
  // ***********************************
  // every offset outside the map reads zero; no page is absent
  always_comb begin
    rd_hit = 1'b1;
    wr_ro = 1'b0;
    unique case (paddr)
      OFF_FEATURE: begin
        rd_val = feature;
        wr_ro = 1'b1;
      end
      OFF_CONTROL: rd_val = control;
      OFF_STATUS: rd_val = status;
      OFF_FAULT_ADDR: rd_val = fault_addr;
      OFF_COUNTER: rd_val = {16'h0000, counter};
      OFF_SCRUB: rd_val = {scrub_en, 15'h0000, scrub_interval};
      OFF_ROUTE: rd_val = {29'h0000_0000, route};
      OFF_GROUP_STATUS: begin
        rd_val = {31'h0000_0000, status[ST_V]};
        wr_ro = 1'b1;
      end
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // counter write while node disabled is an illegal state
  assign wr_state = (paddr == OFF_COUNTER) & ~control[CTL_EN];

  // software fault classification in the access phase
  always_comb begin
    swf = 1'b0;
    swf_code = ETC_NONE;
    if (psel && penable) begin
      if (!rd_hit) begin
        swf = 1'b1;
        swf_code = ETC_ILL_ADDR;
      end else if (pwrite && wr_ro) begin
        swf = 1'b1;
        swf_code = ETC_ILL_ACCESS;
      end else if (pwrite && wr_state) begin
        swf = 1'b1;
        swf_code = ETC_ILL_STATE;
      end
    end
  end

  // ***********************************
  // apb answer
  // ***********************************
  // read data captured in the setup cycle, answer has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  assign pready = 1'b1;
  // in-band error only when software enabled it
  assign pslverr = swf & control[CTL_SWF_RESP];

  // ***********************************
  // control and routing
  // ***********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= CONTROL_RESET;
    end else if (wr_acc && paddr == OFF_CONTROL) begin
      control <= pwdata & CONTROL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route <= ROUTE_RESET;
    end else if (wr_acc && paddr == OFF_ROUTE) begin
      route <= pwdata[2:0];
    end
  end

  // ***********************************
  // corrected error counter
  // ***********************************
  // a hardware count in the same cycle adds one to the value a software write loads
  always_comb begin
    next_counter = counter;
    if (wr_acc && paddr == OFF_COUNTER && !wr_state) begin
      next_counter = pwdata[15:0];
    end
    if (ce_event && control[CTL_EN]) begin
      next_counter[CNT_OV-1:0] = next_counter[CNT_OV-1:0] + 15'h0001;
      if (next_counter[CNT_OV-1:0] == 15'h0000) begin
        next_counter[CNT_OV] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= COUNTER_RESET;
    end else begin
      counter <= next_counter;
    end
  end

  // ***********************************
  // error record status
  // ***********************************
  assign err_any = control[CTL_EN] & (ue_event | de_event | ci_event);
  assign swf_err = swf & ~status[ST_V];

  // flags are write one to clear; a new event wins over the clear
  always_comb begin
    next_status = status;
    if (wr_acc && paddr == OFF_STATUS) begin
      next_status = status & ~(pwdata & 32'hF1C0_0000);
      if (pwdata[ST_V]) begin
        next_status[7:0] = ETC_NONE;
      end
    end
    if (control[CTL_EN] && ce_event) begin
      next_status[ST_CE] = 1'b1;
    end
    if (err_any) begin
      next_status[ST_V] = 1'b1;
      next_status[ST_ADDRV] = 1'b1;
      next_status[ST_UE] = next_status[ST_UE] | ue_event;
      next_status[ST_DE] = next_status[ST_DE] | de_event;
      next_status[ST_CI] = next_status[ST_CI] | ci_event;
      next_status[7:0] = ETC_DATA;
    end else if (swf_err) begin
      next_status[ST_V] = 1'b1;
      next_status[7:0] = swf_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 32'h0000_0000;
    end else begin
      status <= next_status;
    end
  end

  // ***********************************
  // fault address
  // ***********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_addr <= 32'h0000_0000;
    end else if (err_any) begin
      fault_addr <= {~err_addr_spa, err_addr[30:0]};
    end
  end

  // ***********************************
  // cache protection and scrub
  // ***********************************
  // errors arrive already classified by the secded decoder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invalidate_req <= 1'b0;
    end else begin
      invalidate_req <= clean_det;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scrub_en <= 1'b0;
      scrub_interval <= SCRUB_INTERVAL_RESET;
    end else if (wr_acc && paddr == OFF_SCRUB) begin
      scrub_en <= pwdata[SCRUB_EN];
      scrub_interval <= pwdata[15:0];
    end
  end

  // one request every interval+1 cycles while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scrub_cnt <= 16'h0000;
      scrub_req <= 1'b0;
    end else if (!scrub_en) begin
      scrub_cnt <= 16'h0000;
      scrub_req <= 1'b0;
    end else if (scrub_cnt >= scrub_interval) begin
      scrub_cnt <= 16'h0000;
      scrub_req <= 1'b1;
    end else begin
      scrub_cnt <= scrub_cnt + 16'h0001;
      scrub_req <= 1'b0;
    end
  end

  // ***********************************
  // interrupt lines
  // ***********************************
  logic fh_level;
  logic er_level;
  logic ci_level;

  // all records of the group share each line
  assign fh_level = (control[CTL_FI] & status[ST_V] & (status[ST_UE] | status[ST_DE]))
    | (control[CTL_CFI] & counter[CNT_OV])
    | (control[CTL_SWF_IRQ] & status[ST_V] & (status[7:0] >= ETC_ILL_ADDR));
  assign er_level = (control[CTL_UI] & status[ST_UE])
    | (control[CTL_DUI] & status[ST_DE]);
  assign ci_level = status[ST_CI];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fh_irq_ic <= 1'b0;
      fh_irq_scp <= 1'b0;
      er_irq_ic <= 1'b0;
      er_irq_scp <= 1'b0;
      ci_irq_scp <= 1'b0;
      ci_irq_ic <= 1'b0;
    end else begin
      fh_irq_ic <= fh_level;
      fh_irq_scp <= fh_level & route[ROUTE_FH_SCP];
      er_irq_ic <= er_level;
      er_irq_scp <= er_level & route[ROUTE_ER_SCP];
      ci_irq_scp <= ci_level;
      ci_irq_ic <= ci_level & route[ROUTE_CI_IC];
    end
  end

  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_unmapped;
    psel && !penable && !pwrite && !rd_hit;
  endsequence

  a_counter_step: assert property (
    (ce_event && control[CTL_EN] && !(wr_acc && paddr == OFF_COUNTER)
      && counter[14:0] != 15'h7FFF)
    |=> (counter[14:0] == $past(counter[14:0]) + 15'h0001))
    else $error("counter did not step");

  a_overflow_sticky: assert property (
    (counter[CNT_OV] && !(wr_acc && paddr == OFF_COUNTER)) |=> counter[CNT_OV])
    else $error("overflow bit lost");

  a_overflow_wrap: assert property (
    (ce_event && control[CTL_EN] && counter[14:0] == 15'h7FFF
      && !(wr_acc && paddr == OFF_COUNTER))
    |=> (counter[CNT_OV] && counter[14:0] == 15'h0000))
    else $error("wrap did not set overflow");

  a_feature_fields: assert property (
    (setup && !pwrite && paddr == OFF_FEATURE)
    |=> (prdata[FR_UI +: 2] >= 2'h2 && prdata[FR_DUI +: 2] >= 2'h2
      && prdata[FR_CFI +: 2] >= 2'h2))
    else $error("feature field below 0b10");

  a_addr_type: assert property (
    err_any |=> (fault_addr[ADDR_TYPE_BIT] == !$past(err_addr_spa)))
    else $error("address type flag wrong");

  a_group_mirror: assert property (
    (psel && !penable && !pwrite && paddr == OFF_GROUP_STATUS)
    |=> (prdata[0] == $past(status[ST_V])))
    else $error("group status mismatch");

  a_unmapped_zero: assert property (
    s_read_unmapped |=> (prdata == 32'h0000_0000) ##1 1'b1)
    else $error("unmapped read not zero");

  a_swf_code: assert property (
    (psel && penable && !rd_hit && !status[ST_V] && !err_any)
    |=> (status[7:0] == 8'h0D))
    else $error("illegal address code wrong");

  a_no_err_default: assert property (
    (swf && !control[CTL_SWF_RESP]) |-> !pslverr)
    else $error("error response while disabled");

  a_invalidate: assert property (
    clean_det |=> invalidate_req)
    else $error("clean line not invalidated");

  a_er_level: assert property (
    (control[CTL_UI] && status[ST_UE]) |=> er_irq_ic)
    else $error("recovery interrupt missing");

endmodule : ras_error_node
`default_nettype wire

// [ras_event_src.sv]
// error source model standing at the node's event inputs
`timescale 1ns/10ps
`default_nettype none
module ras_event_src (
  input wire logic pclk, // node clock
  output logic ce_event, // corrected error pulse
  output logic de_event, // deferred error pulse
  output logic ue_event, // uncorrected error pulse
  output logic ci_event, // critical error pulse
  output logic [31:0] err_addr, // address of the error
  output logic err_addr_spa, // address is the system address
  output logic clean_det // clean line error pulse
);
  initial begin
    {ce_event, de_event, ue_event, ci_event, clean_det} = 5'h00;
    err_addr = 32'h5A5A_5A5A;
    err_addr_spa = 1'b0;
  end

  // kind 0 ce, 1 de, 2 ue, 3 ci, 4 clean line error
  task automatic fire(input int kind, input logic [31:0] a, input logic system_physical_address);
    @(posedge pclk);
    {ce_event, de_event, ue_event, ci_event, clean_det} <= 5'h01 << (4 - kind);
    err_addr <= a;
    err_addr_spa <= system_physical_address;
    @(posedge pclk);
    {ce_event, de_event, ue_event, ci_event, clean_det} <= 5'h00;
    // address no longer valid: show something else
    err_addr <= ~a;
    err_addr_spa <= ~system_physical_address;
  endtask : fire
endmodule : ras_event_src
`default_nettype wire

// [ras_error_node_tb.sv]
// self-checking bench for the error reporting node
`timescale 1ns/10ps
`default_nettype none
module ras_error_node_tb;
  import ras_node_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, err_addr, q;
  logic pready, pslverr, error_type_code;
  logic ce_event, de_event, ue_event, ci_event, err_addr_spa, clean_det;
  logic invalidate_req, scrub_req, fh_irq_ic, fh_irq_scp;
  logic er_irq_ic, er_irq_scp, ci_irq_scp, ci_irq_ic;
  logic [31:0] rnd = 32'hB6B9_155A;
  logic [11:0] fault_addr [3] = '{12'h100, OFF_FEATURE, OFF_COUNTER};
  int num_errors = 0;
  int checks_done = 0;
  int n;

  always #20 pclk = ~pclk;

  ras_error_node u_ras_error_node (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ce_event, .de_event, .ue_event, .ci_event,
    .err_addr, .err_addr_spa, .clean_det, .invalidate_req, .scrub_req, .fh_irq_ic,
    .fh_irq_scp, .er_irq_ic, .er_irq_scp, .ci_irq_scp, .ci_irq_ic);

  ras_event_src u_ras_event_src (.pclk, .ce_event, .de_event, .ue_event, .ci_event,
    .err_addr, .err_addr_spa, .clean_det);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'hA300_0000) : (s >> 1);
  endfunction : lfsr

  function automatic logic [31:0] addr_exp(input logic [31:0] a, input logic system_physical_address);
    return {~system_physical_address, a[30:0]};
  endfunction : addr_exp

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    error_type_code = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_FEATURE, 32'h0000_48A8);
    rd(OFF_CONTROL, 32'h0000_0000);
    rd(OFF_COUNTER, 32'h0000_0000);
    rd(OFF_SCRUB, 32'h0000_0100);
    rd(OFF_ROUTE, 32'h0000_0000);
    $display("reset values done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
      apb(i != 0, fault_addr[i], 32'h0000_1234);
      if (i == 0) chk(q, 32'h0000_0000);
      rd(OFF_STATUS, 32'h4000_0000 | (32'h0D + i));
    end
    rd(OFF_FEATURE, 32'h0000_48A8);
    rd(OFF_COUNTER, 32'h0000_0000);
    apb(1'b1, OFF_CONTROL, 32'h0000_1000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk(error_type_code, 1'b1);
    apb(1'b1, OFF_CONTROL, 32'h0000_010D);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk(error_type_code, 1'b0);
    apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
    $display("software faults done");
    n = rnd[3:0] + 1;
    repeat (n) u_ras_event_src.fire(0, rnd, 1'b0);
    rd(OFF_COUNTER, n);
    apb(1'b1, OFF_COUNTER, 32'h0000_7FFF);
    u_ras_event_src.fire(0, rnd, 1'b0);
    rd(OFF_COUNTER, 32'h0000_8000);
    chk(fh_irq_ic, 1'b1);
    apb(1'b1, OFF_COUNTER, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(fh_irq_ic, 1'b0);
    $display("counter done");
    apb(1'b1, OFF_CONTROL, 32'h0000_030D);
    apb(1'b1, OFF_ROUTE, 32'h0000_0006);
    for (int s = 0; s < 2; s++) begin
      rnd = lfsr(rnd);
      u_ras_event_src.fire(2 - s, rnd, s[0]);
      repeat (2) @(posedge pclk);
      chk(er_irq_ic, 1'b1);
      chk(er_irq_scp, 1'b1);
      chk(fh_irq_scp, 1'b1);
      rd(OFF_FAULT_ADDR, addr_exp(rnd, s[0]));
      rd(OFF_GROUP_STATUS, 32'h0000_0001);
      apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
      repeat (3) @(posedge pclk);
      chk(er_irq_ic, 1'b0);
      chk(fh_irq_scp, 1'b0);
      rd(OFF_GROUP_STATUS, 32'h0000_0000);
    end
    apb(1'b1, OFF_ROUTE, 32'h0000_0001);
    u_ras_event_src.fire(3, rnd, 1'b1);
    repeat (2) @(posedge pclk);
    chk(ci_irq_ic, 1'b1);
    chk(ci_irq_scp, 1'b1);
    apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
    $display("interrupts done");
    u_ras_event_src.fire(4, rnd, 1'b0);
    #1 chk(invalidate_req, 1'b1);
    @(posedge pclk);
    #1 chk(invalidate_req, 1'b0);
    apb(1'b1, OFF_SCRUB, 32'h8000_0003);
    n = 0;
    repeat (41) begin
      @(posedge pclk);
      if (scrub_req === 1'b1) n++;
    end
    chk(n, 32'd10);
    apb(1'b1, OFF_SCRUB, 32'h0000_0000);
    $display("invalidate and scrub done");
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
endmodule : ras_error_node_tb
`default_nettype wire
